/* File: hdl/tx_packet_checker_lpi_gen.sv */
// Purpose: tx frame statistics and generator LPI gap timing
// Assumes: byte stream, en high from preamble to last FCS byte
// Notes:   AXI4-Lite slave, 16-bit registers in low lanes
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Count good-CRC frames under 64 bytes in a 32-bit counter.
// - Expose it as high and low halves; reading a half clears it.
// - Count bad-CRC frames of 64 to 1518 bytes, 16-bit, read-clear.
// - Count bad-CRC frames over 1518 bytes, 16-bit, read-clear.
// - Count MAC frames under 64 bytes regardless of CRC, read-clear.
// - Count MAC frames lacking the start delimiter, read-clear.
// - Config bit 1 picks generator data, else MAC data; resets 0.
// - Config bit 0 enables LPI in generator gaps; resets 0.
// - Wait 11-bit microseconds after a packet before LPI.
// - Send LPI for an 11-bit number of microseconds.
// - Hold idle 11-bit microseconds after LPI before next packet.
module tx_packet_checker_lpi_gen
    import tx_pkt_chk_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Transmit byte streams
    input  wire txbyte_s           macTx,
    input  wire txbyte_s           genTx,
    // Generator gap control and interrupt
    output logic                   lpiSend,
    output logic                   genHold,
    output logic                   irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    logic              awReady_r, wReady_r, bValid_r, arReady_r, rValid_r;
    logic              awHeld_r, wHeld_r;
    logic [IDX_W-1:0]  awIdx_r;
    logic [31:0]       wData_r;
    logic [3:0]        wStrb_r;
    logic [1:0]        bResp_r, rResp_r;
    logic [31:0]       rData_r;
    logic [1:0]        cfg_r;
    logic [15:0]       pre_r, lpi_r, post_r;
    logic [EV_W-1:0]   mask_r, sts_r, ev_r, evNxt, stsNxt;
    logic              irq_r;
    logic [31:0]       us_r, usBase, us_nxt;
    logic [15:0]       cnt_r [4];
    logic              prevEn_r, sfd_r, lost_r;
    logic              sfd_nxt, lost_nxt;
    logic [11:0]       len_r, len_nxt;
    logic [31:0]       crc_r, crc_nxt;
    gap_e              gap_r, gap_nxt;
    logic [TIME_W-1:0] left_r, left_nxt;
    logic [7:0]        div_r;
    logic              genPrev_r, lpi_o_r, hold_r;

    // Bus handshakes
    wire awHs = s_axi_awvalid & awReady_r;
    wire wHs  = s_axi_wvalid & wReady_r;
    wire doWr = awHeld_r & wHeld_r & ~bValid_r;
    wire arHs = s_axi_arvalid & arReady_r;
    wire [IDX_W-1:0] rIdx = s_axi_araddr[ADDR_W-1:2];

    // Read decode
    wire rUsHi = rIdx == IDX_US_HI;
    wire rUsLo = rIdx == IDX_US_LO;
    wire rBad  = rIdx == IDX_BAD;
    wire rOs   = rIdx == IDX_OS_BAD;
    wire rFrag = rIdx == IDX_FRAG;
    wire rNsfd = rIdx == IDX_NOSFD;
    wire rCfg  = rIdx == IDX_CFG;
    wire rPre  = rIdx == IDX_PRE;
    wire rLpi  = rIdx == IDX_LPI;
    wire rPost = rIdx == IDX_POST;
    wire rSts  = rIdx == IDX_STATUS;
    wire rMask = rIdx == IDX_MASK;
    wire rHit  = rUsHi | rUsLo | rBad | rOs | rFrag | rNsfd | rCfg
               | rPre | rLpi | rPost | rSts | rMask;
    wire [15:0] rVal =
          ({16{rUsHi}} & us_r[31:16]) | ({16{rUsLo}} & us_r[15:0])
        | ({16{rBad}}  & cnt_r[0])    | ({16{rOs}}   & cnt_r[1])
        | ({16{rFrag}} & cnt_r[2])    | ({16{rNsfd}} & cnt_r[3])
        | ({16{rCfg}}  & {14'h0000, cfg_r})
        | ({16{rPre}}  & pre_r) | ({16{rLpi}} & lpi_r)
        | ({16{rPost}} & post_r)
        | ({16{rSts}}  & {10'h000, sts_r})
        | ({16{rMask}} & {10'h000, mask_r});
    wire [3:0] clr16 = {rNsfd, rFrag, rOs, rBad} & {4{arHs}};

    // Write decode
    wire wCfg  = doWr & (awIdx_r == IDX_CFG);
    wire wPre  = doWr & (awIdx_r == IDX_PRE);
    wire wLpi  = doWr & (awIdx_r == IDX_LPI);
    wire wPost = doWr & (awIdx_r == IDX_POST);
    wire wMask = doWr & (awIdx_r == IDX_MASK);
    wire wRo   = (awIdx_r >= IDX_US_HI) & (awIdx_r <= IDX_NOSFD)
               | (awIdx_r == IDX_STATUS);
    wire wHit  = wCfg | wPre | wLpi | wPost | wMask | (doWr & wRo);

    function automatic logic [15:0] merge(input logic [15:0] o);
        merge[7:0]  = wStrb_r[0] ? wData_r[7:0]  : o[7:0];
        merge[15:8] = wStrb_r[1] ? wData_r[15:8] : o[15:8];
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awReady_r <= 1'b1;
            wReady_r  <= 1'b1;
            awHeld_r  <= 1'b0;
            wHeld_r   <= 1'b0;
            awIdx_r   <= 16'h0000;
            wData_r   <= 32'h00000000;
            wStrb_r   <= 4'h0;
            bValid_r  <= 1'b0;
            bResp_r   <= RESP_OKAY;
        end else begin
            if (awHs) begin
                awHeld_r  <= 1'b1;
                awReady_r <= 1'b0;
                awIdx_r   <= s_axi_awaddr[ADDR_W-1:2];
            end
            if (wHs) begin
                wHeld_r  <= 1'b1;
                wReady_r <= 1'b0;
                wData_r  <= s_axi_wdata;
                wStrb_r  <= s_axi_wstrb;
            end
            if (doWr) begin
                awHeld_r  <= 1'b0;
                wHeld_r   <= 1'b0;
                awReady_r <= 1'b1;
                wReady_r  <= 1'b1;
                bValid_r  <= 1'b1;
                bResp_r   <= wHit ? RESP_OKAY : RESP_SLVERR;
            end else if (bValid_r & s_axi_bready) begin
                bValid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arReady_r <= 1'b1;
            rValid_r  <= 1'b0;
            rData_r   <= 32'h00000000;
            rResp_r   <= RESP_OKAY;
        end else if (arHs) begin
            arReady_r <= 1'b0;
            rValid_r  <= 1'b1;
            rData_r   <= {16'h0000, rVal};
            rResp_r   <= rHit ? RESP_OKAY : RESP_SLVERR;
        end else if (rValid_r & s_axi_rready) begin
            rValid_r  <= 1'b0;
            arReady_r <= 1'b1;
        end
    end

    // Configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_r  <= 2'h0;
            pre_r  <= 16'h0000;
            lpi_r  <= 16'h0000;
            post_r <= 16'h0000;
            mask_r <= 6'h00;
        end else begin
            if (wCfg)  cfg_r  <= 2'(merge({14'h0000, cfg_r}));
            if (wPre)  pre_r  <= merge(pre_r);
            if (wLpi)  lpi_r  <= merge(lpi_r);
            if (wPost) post_r <= merge(post_r);
            if (wMask) mask_r <= EV_W'(merge({10'h000, mask_r}));
        end
    end

    // Checker input select
    wire     useGen = cfg_r[CFG_SRC];
    txbyte_s chkIn;
    assign chkIn = useGen ? genTx : macTx;
    wire startF  = chkIn.en & ~prevEn_r;
    wire endF    = prevEn_r & ~chkIn.en;
    wire frameOk = sfd_r & ~lost_r;
    wire crcOk   = crc_r == CRC_RES;
    wire isShort = len_r < LEN_MIN;
    wire isLong  = len_r > LEN_MAX;

    function automatic logic [31:0] crcByte(input logic [31:0] c,
                                            input logic [7:0]  d);
        logic [31:0] x;
        x = c;
        for (int i = 0; i < 8; i++) begin
            x = (x >> 1) ^ (CRC_POLY & {32{x[0] ^ d[i]}});
        end
        crcByte = x;
    endfunction

    // Preamble, delimiter, length and CRC tracking
    always_comb begin
        sfd_nxt  = startF ? 1'b0 : sfd_r;
        lost_nxt = startF ? 1'b0 : lost_r;
        len_nxt  = startF ? 12'h000 : len_r;
        crc_nxt  = startF ? CRC_INIT : crc_r;
        if (chkIn.en & ~lost_nxt) begin
            if (~sfd_nxt) begin
                if (chkIn.dat == SFD_BYTE) sfd_nxt = 1'b1;
                else if (chkIn.dat != PRE_BYTE) lost_nxt = 1'b1;
            end else begin
                if (len_nxt != 12'hFFF) len_nxt = len_nxt + 12'h001;
                crc_nxt = crcByte(crc_nxt, chkIn.dat);
            end
        end
    end

    // Frame-end classification and LPI gap exit event
    always_comb begin
        evNxt           = '0;
        evNxt[EV_US]    = endF & frameOk & crcOk & isShort;
        evNxt[EV_BAD]   = endF & frameOk & ~crcOk & ~isShort
                        & ~isLong;
        evNxt[EV_OS]    = endF & frameOk & ~crcOk & isLong;
        evNxt[EV_FRAG]  = endF & ~useGen & frameOk & isShort;
        evNxt[EV_NOSFD] = endF & ~useGen & ~frameOk;
        evNxt[EV_LPI]   = (gap_r == GAP_POST) & (gap_nxt == GAP_RUN);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevEn_r <= 1'b0;
            sfd_r    <= 1'b0;
            lost_r   <= 1'b0;
            len_r    <= 12'h000;
            crc_r    <= CRC_INIT;
            ev_r     <= 6'h00;
        end else begin
            prevEn_r <= chkIn.en;
            sfd_r    <= sfd_nxt;
            lost_r   <= lost_nxt;
            len_r    <= len_nxt;
            crc_r    <= crc_nxt;
            ev_r     <= evNxt;
        end
    end

    chk_us_good: assert property (endF & frameOk & crcOk & isShort
        |=> ev_r[EV_US]) else $error("undersize good missed");
    chk_bad_range: assert property (endF & frameOk & ~crcOk & ~isShort
        & ~isLong |=> ev_r[EV_BAD] & ~ev_r[EV_OS])
        else $error("bad crc frame missed");
    chk_os_bad: assert property (endF & frameOk & ~crcOk & isLong
        |=> ev_r[EV_OS] & ~ev_r[EV_BAD])
        else $error("oversize bad crc missed");
    chk_frag_mac: assert property (ev_r[EV_FRAG]
        |-> $past(endF & ~useGen & isShort))
        else $error("fragment without cause");
    chk_nosfd_mac: assert property (endF & ~cfg_r[CFG_SRC] & ~frameOk
        |=> ev_r[EV_NOSFD]) else $error("no sfd missed");

    // Undersize counter: a read clears the half it returns
    always_comb begin
        usBase = us_r;
        if (arHs & rUsHi) usBase[31:16] = 16'h0000;
        if (arHs & rUsLo) usBase[15:0]  = 16'h0000;
        us_nxt = usBase;
        // Clear applies first so a same-cycle event is kept
        if (ev_r[EV_US] & (usBase != 32'hFFFFFFFF))
            us_nxt = usBase + 32'h00000001;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) us_r <= 32'h00000000;
        else     us_r <= us_nxt;
    end

    // Four 16-bit read-clear counters
    for (genvar k = 0; k < 4; k++) begin : g_cnt
        wire [15:0] base = clr16[k] ? 16'h0000 : cnt_r[k];
        wire        inc  = ev_r[EV_BAD+k] & (base != 16'hFFFF);
        always_ff @(posedge clk or posedge rst) begin
            if (rst) cnt_r[k] <= 16'h0000;
            else     cnt_r[k] <= inc ? base + 16'h0001 : base;
        end
        chk_sat_hold: assert property (cnt_r[k] == 16'hFFFF & ~clr16[k]
            |=> cnt_r[k] == 16'hFFFF)
            else $error("counter wrapped");
        chk_clr_keep: assert property (clr16[k] & ev_r[EV_BAD+k]
            |=> cnt_r[k] == 16'h0001)
            else $error("event lost on clear");
    end

    // Status, mask and interrupt
    wire clrSts = arHs & rSts;
    assign stsNxt = (clrSts ? 6'h00 : sts_r) | ev_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sts_r <= 6'h00;
            irq_r <= 1'b0;
        end else begin
            sts_r <= stsNxt;
            irq_r <= |(stsNxt & mask_r);
        end
    end

    // Generator gap timer, microsecond granularity
    wire genEnd = genPrev_r & ~genTx.en;
    wire tick   = div_r == 8'(US_CYCLES - 1);
    wire gapEn  = cfg_r[CFG_LPI_EN];
    always_comb begin
        gap_nxt  = gap_r;
        left_nxt = left_r;
        unique case (gap_r)
            GAP_RUN: begin
                if (genEnd & gapEn) begin
                    gap_nxt  = GAP_PRE;
                    left_nxt = pre_r[TIME_W-1:0];
                end
            end
            GAP_PRE: begin
                if (left_r == '0) begin
                    gap_nxt  = GAP_LPI;
                    left_nxt = lpi_r[TIME_W-1:0];
                end else if (tick) left_nxt = left_r - 11'h001;
            end
            GAP_LPI: begin
                if (left_r == '0) begin
                    gap_nxt  = GAP_POST;
                    left_nxt = post_r[TIME_W-1:0];
                end else if (tick) left_nxt = left_r - 11'h001;
            end
            GAP_POST: begin
                if (left_r == '0) gap_nxt = GAP_RUN;
                else if (tick) left_nxt = left_r - 11'h001;
            end
            default: gap_nxt = GAP_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_r     <= GAP_RUN;
            left_r    <= 11'h000;
            div_r     <= 8'h00;
            genPrev_r <= 1'b0;
            lpi_o_r   <= 1'b0;
            hold_r    <= 1'b0;
        end else begin
            gap_r     <= gap_nxt;
            left_r    <= left_nxt;
            // Restart the divider per phase so each lasts whole us
            div_r     <= (gap_nxt != gap_r) | tick ? 8'h00
                                                   : div_r + 8'h01;
            genPrev_r <= genTx.en;
            lpi_o_r   <= gap_nxt == GAP_LPI;
            hold_r    <= gap_nxt != GAP_RUN;
        end
    end

    sequence seqEnter(gap_e s);
        gap_r != s ##1 gap_r == s;
    endsequence
    chk_lpi_off: assert property (gap_r == GAP_RUN & ~gapEn
        |=> gap_r == GAP_RUN) else $error("lpi while off");
    chk_pre_wait: assert property (seqEnter(GAP_PRE) ##0 left_r != '0
        |-> (gap_r == GAP_PRE)[*8]) else $error("pre wait short");
    chk_lpi_span: assert property (seqEnter(GAP_LPI) ##0 left_r != '0
        |=> lpiSend[*8]) else $error("lpi cut short");
    chk_post_hold: assert property ($fell(lpiSend) |-> genHold)
        else $error("post idle not held");

    assign s_axi_awready = awReady_r;
    assign s_axi_wready  = wReady_r;
    assign s_axi_bvalid  = bValid_r;
    assign s_axi_bresp   = bResp_r;
    assign s_axi_arready = arReady_r;
    assign s_axi_rvalid  = rValid_r;
    assign s_axi_rdata   = rData_r;
    assign s_axi_rresp   = rResp_r;
    assign lpiSend       = lpi_o_r;
    assign genHold       = hold_r;
    assign irq           = irq_r;
endmodule
`default_nettype wire

/* File: hdl/tx_pkt_chk_pkg.sv */
// Purpose: constants and types for the tx checker and gap timer
// Assumes: 250 MHz core clock
// Notes:   register index times four gives the byte address
package tx_pkt_chk_pkg;
    localparam int ADDR_W = 18;
    localparam int IDX_W  = 16;
    localparam logic [15:0] IDX_US_HI  = 16'h40B1;
    localparam logic [15:0] IDX_US_LO  = 16'h40B2;
    localparam logic [15:0] IDX_BAD    = 16'h40B3;
    localparam logic [15:0] IDX_OS_BAD = 16'h40B4;
    localparam logic [15:0] IDX_FRAG   = 16'h40B5;
    localparam logic [15:0] IDX_NOSFD  = 16'h40B6;
    localparam logic [15:0] IDX_CFG    = 16'h40B7;
    localparam logic [15:0] IDX_PRE    = 16'h40B8;
    localparam logic [15:0] IDX_LPI    = 16'h40B9;
    localparam logic [15:0] IDX_POST   = 16'h40BA;
    localparam logic [15:0] IDX_STATUS = 16'h40BB;
    localparam logic [15:0] IDX_MASK   = 16'h40BC;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam int CFG_LPI_EN = 0;
    localparam int CFG_SRC    = 1;
    localparam int TIME_W     = 11;
    localparam int EV_US      = 0;
    localparam int EV_BAD     = 1;
    localparam int EV_OS      = 2;
    localparam int EV_FRAG    = 3;
    localparam int EV_NOSFD   = 4;
    localparam int EV_LPI     = 5;
    localparam int EV_W       = 6;
    localparam logic [7:0]  PRE_BYTE = 8'h55;
    localparam logic [7:0]  SFD_BYTE = 8'hD5;
    localparam logic [11:0] LEN_MIN  = 12'h040;
    localparam logic [11:0] LEN_MAX  = 12'h5EE;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_RES  = 32'hDEBB20E3;
    localparam int CLK_PS    = 4000;
    localparam int US_PS     = 1000000;
    localparam int US_CYCLES = US_PS / CLK_PS;
    typedef struct packed {
        logic       en;
        logic [7:0] dat;
    } txbyte_s;
    typedef enum logic [3:0] {
        GAP_RUN  = 4'b0001,
        GAP_PRE  = 4'b0010,
        GAP_LPI  = 4'b0100,
        GAP_POST = 4'b1000
    } gap_e;
endpackage

/* File: tb/frame_source.sv */
// Purpose: byte stream source standing in for the MAC or the generator
// Assumes: length counts bytes after the delimiter, FCS included
// Notes:   idle data keeps toggling, so a stale byte never looks valid
`timescale 1ns/1ps
`default_nettype none
module frame_source
    import tx_pkt_chk_pkg::*;
(
    // Clock
    input  wire logic    clk,
    // Byte stream towards the checker
    output wire txbyte_s tx
);
    logic       enR  = 1'b0;
    logic [7:0] datR = 8'h00;
    logic       busy = 1'b0;

    assign tx = '{en: enR, dat: datR};

    always @(posedge clk)
        if (!busy) datR <= ~datR;

    // A bad frame flips one FCS bit; a frame without delimiter shows a foreign byte
    task automatic send(input int len, input bit good, input bit sfd);
        logic [31:0] crc;
        logic [7:0]  b;
        crc  = CRC_INIT;
        busy = 1'b1;
        for (int i = 0; i < len + 8; i++) begin
            if (i < 7)
                b = PRE_BYTE;
            else if (i == 7)
                b = sfd ? SFD_BYTE : 8'h3C;
            else if (i < len + 4) begin
                b = 8'(i * 37);
                for (int j = 0; j < 8; j++)
                    crc = (crc >> 1) ^ ((crc[0] ^ b[j]) ? CRC_POLY : 32'h0);
            end else
                b = 8'(~crc >> (8 * (i - len - 4))) ^ {7'h0, !good && i == len + 4};
            @(posedge clk);
            enR  <= 1'b1;
            datR <= b;
        end
        @(posedge clk);
        enR  <= 1'b0;
        busy <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: tb/tx_packet_checker_lpi_gen_tb.sv */
// Purpose: self-checking bench for the tx checker and gap timer
// Assumes: 250 MHz clock, bus tasks wait for every handshake
// Notes:   counter saturation is not reached, it would take too long
`timescale 1ns/1ps
`default_nettype none
module tx_packet_checker_lpi_gen_tb
    import tx_pkt_chk_pkg::*;
;
    logic              clk     = 1'b0;
    logic              rst     = 1'b1;
    logic [ADDR_W-1:0] awaddr  = '0;
    logic              awvalid = 1'b0;
    logic              awready;
    logic [31:0]       wdata   = '0;
    logic              wvalid  = 1'b0;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready  = 1'b0;
    logic [ADDR_W-1:0] araddr  = '0;
    logic              arvalid = 1'b0;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready  = 1'b0;
    wire txbyte_s      macTx;
    wire txbyte_s      genTx;
    logic              lpiSend;
    logic              genHold;
    logic              irq;
    int                error_cnt = 0;
    int                checked   = 0;
    int                seed      = 98102;
    int                k;
    int                holdCnt;
    int                lpiCnt;
    int                preCnt;
    int                bad;
    bit                srcGen    = 1'b0;
    logic [31:0]       expCnt [5] = '{default: 0};
    logic [31:0]       d;
    logic [1:0]        r;
    localparam logic [15:0] CNT_IDX [5] = '{IDX_US_LO, IDX_BAD, IDX_OS_BAD, IDX_FRAG, IDX_NOSFD};

    always #2 clk = ~clk;

    tx_packet_checker_lpi_gen DUT (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .macTx(macTx), .genTx(genTx), .lpiSend(lpiSend), .genHold(genHold), .irq(irq)
    );
    frame_source macSrc (.clk(clk), .tx(macTx));
    frame_source genSrc (.clk(clk), .tx(genTx));

    task automatic tally_and_finish();
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] v, input logic [1:0] resp);
        awaddr  <= {idx, 2'b00};
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk("write response", bresp, resp);
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [15:0] idx, output logic [31:0] v, output logic [1:0] resp);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0]  resp;
        rd(idx, v, resp);
        chk($sformatf("register %h", idx), v, exp);
        chk("read response", resp, RESP_OKAY);
    endtask

    // Expected events of one frame when its source is the selected one
    function automatic logic [4:0] classify(input int len, input bit good, input bit sfd, input bit gen);
        classify = '0;
        if (!sfd)
            classify[EV_NOSFD] = !gen;
        else begin
            classify[EV_US]   = good && len < 64;
            classify[EV_BAD]  = !good && len >= 64 && len <= 1518;
            classify[EV_OS]   = !good && len > 1518;
            classify[EV_FRAG] = !gen && len < 64;
        end
    endfunction

    task automatic frame(input int len, input bit good, input bit sfd, input bit gen);
        logic [4:0] ev;
        ev = (gen == srcGen) ? classify(len, good, sfd, gen) : 5'h0;
        if (gen)
            genSrc.send(len, good, sfd);
        else
            macSrc.send(len, good, sfd);
        for (int i = 0; i < 5; i++)
            expCnt[i] += ev[i];
        repeat (3) @(posedge clk);
    endtask

    task automatic checkCounts();
        rdchk(IDX_US_HI, 32'h0);
        for (int i = 0; i < 5; i++)
            rdchk(CNT_IDX[i], expCnt[i]);
        for (int i = 0; i < 5; i++)
            rdchk(CNT_IDX[i], 32'h0);
        expCnt = '{default: 0};
    endtask

    initial begin
        #400000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 16'h40B1; i <= 16'h40BC; i++)
            rdchk(16'(i), 32'h0);
        wr(16'h40BF, 32'h1234, RESP_SLVERR);
        rd(16'h40BF, d, r);
        chk("unmapped response", r, RESP_SLVERR);
        chk("unmapped data", d, 32'h0);
        for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            wr(IDX_PRE + 16'(i), d, RESP_OKAY);
            rdchk(IDX_PRE + 16'(i), {16'h0, d[15:0]});
        end
        wr(IDX_CFG, 32'hFFFF, RESP_OKAY);
        rdchk(IDX_CFG, 32'h3);
        wr(IDX_CFG, 32'h0, RESP_OKAY);
        wr(IDX_FRAG, 32'hFFFF, RESP_OKAY);
        // Length boundaries first, then random frames from the MAC side
        frame(63, 1, 1, 0);
        frame(64, 0, 1, 0);
        frame(1518, 0, 1, 0);
        frame(1519, 0, 1, 0);
        frame(64, 1, 1, 0);
        frame(20, 0, 1, 0);
        frame(30, 1, 0, 0);
        frame(40, 1, 1, 1);
        for (int n = 0; n < 24; n++) begin
            k = $unsigned($random(seed)) % 5;
            case (k)
                0: frame(8 + $unsigned($random(seed)) % 56, 1, 1, 0);
                1: frame(64 + $unsigned($random(seed)) % 1455, 0, 1, 0);
                2: frame(1519 + $unsigned($random(seed)) % 16, 0, 1, 0);
                3: frame(8 + $unsigned($random(seed)) % 56, 0, 1, 0);
                default: frame(8 + $unsigned($random(seed)) % 100, 1, 0, 0);
            endcase
        end
        checkCounts();
        wr(IDX_CFG, 32'h2, RESP_OKAY);
        srcGen = 1'b1;
        frame(40, 1, 1, 1);
        frame(20, 0, 1, 1);
        frame(100, 0, 1, 1);
        frame(40, 1, 1, 0);
        frame(10, 0, 0, 0);
        checkCounts();
        rd(IDX_STATUS, d, r);
        wr(IDX_MASK, 32'h1, RESP_OKAY);
        frame(100, 0, 1, 1);
        chk("irq masked", irq, 1'b0);
        frame(50, 1, 1, 1);
        chk("irq raised", irq, 1'b1);
        rdchk(IDX_STATUS, 32'h3);
        @(posedge clk);
        chk("irq cleared", irq, 1'b0);
        // Upper bits of a time register must not stretch the phase
        wr(IDX_PRE, 32'h1, RESP_OKAY);
        wr(IDX_LPI, 32'h2, RESP_OKAY);
        wr(IDX_POST, 32'hF801, RESP_OKAY);
        wr(IDX_MASK, 32'h20, RESP_OKAY);
        wr(IDX_CFG, 32'h3, RESP_OKAY);
        frame(70, 1, 1, 1);
        holdCnt = 0;
        lpiCnt = 0;
        preCnt = 0;
        bad = 0;
        k = 0;
        while ((genHold || k == 0) && k < 3000) begin
            @(posedge clk);
            k++;
            holdCnt += int'(genHold);
            lpiCnt += int'(lpiSend);
            if (lpiCnt == 0 && genHold) preCnt++;
            if (lpiSend && !genHold) bad++;
        end
        chk("pre gap length", preCnt >= 244 && preCnt <= 252, 1'b1);
        chk("lpi length", lpiCnt >= 498 && lpiCnt <= 504, 1'b1);
        chk("hold length", holdCnt >= 995 && holdCnt <= 1004, 1'b1);
        chk("lpi outside hold", bad, 32'h0);
        // Status and irq settle one edge after the timer returns to run
        repeat (2) @(posedge clk);
        chk("irq after lpi", irq, 1'b1);
        rdchk(IDX_STATUS, 32'h20);
        wr(IDX_CFG, 32'h2, RESP_OKAY);
        frame(70, 1, 1, 1);
        repeat (20) @(posedge clk);
        chk("hold while disabled", genHold, 1'b0);
        chk("lpi while disabled", lpiSend, 1'b0);
        checkCounts();
        tally_and_finish();
    end
endmodule
`default_nettype wire
